// ---- design/rhf_pkg.sv ----
// Constants and carrier types of the host framed transmit framer
package rhf_pkg;
  localparam logic [7:0]  START_BYTE     = 8'h81;
  localparam logic [7:0]  MAX_PAYLOAD    = 8'h80;
  localparam logic [7:0]  HDR_BYTES      = 8'h07;
  localparam int          BUF_BYTES      = 256;
  localparam logic [7:0]  ALL_ONES_BYTE  = 8'hff;
  localparam logic [7:0]  CHAN_MIN       = 8'h10;
  localparam logic [7:0]  CHAN_MAX       = 8'h2f;
  localparam logic [7:0]  COUNT_DEFAULT  = 8'h04;
  localparam logic [7:0]  COUNT_MIN      = 8'h02;
  localparam logic [15:0] LFSR_SEED      = 16'hace1;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          CLK_MHZ        = 250;
  localparam int          ACK_WAIT_NS    = 2000;
  localparam int          ACK_WAIT_CYC   = (ACK_WAIT_NS * CLK_MHZ) / 1000;
  localparam int          BACKOFF_SLOT_NS  = 400;
  localparam int          BACKOFF_SLOT_CYC = (BACKOFF_SLOT_NS * CLK_MHZ + 999) / 1000;
  localparam int          RAW_GAP_NS     = 40000;
  localparam int          RAW_GAP_CYC    = (RAW_GAP_NS * CLK_MHZ) / 1000;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_HDR     = 7'h02,
    ST_PAY     = 7'h04,
    ST_RAW     = 7'h08,
    ST_SEND    = 7'h10,
    ST_WAIT    = 7'h20,
    ST_BACKOFF = 7'h40
  } rhf_state_t;

  typedef enum logic [1:0] {
    DLV_BCAST = 2'h0,
    DLV_AUTO  = 2'h1,
    DLV_ADDR  = 2'h2
  } rhf_dlv_t;

  typedef struct packed {
    logic [7:0] chan;
    logic [8:0] sysid;
  } rhf_netid_t;

  typedef struct packed {
    logic [47:0] src;
    logic [47:0] dest;
    rhf_netid_t  net;
    logic        bcast;
  } rhf_rx_hdr_t;

  typedef struct packed {
    logic [47:0] dest;
    logic        bcast;
    logic        enc;
    logic [55:0] key;
    rhf_netid_t  net;
    logic        nine_bit;
    logic        odd;
  } rhf_tx_hdr_t;
endpackage

// ---- design/rhf_fifo.sv ----
// Byte FIFO between the host serial stream and the framer
`timescale 1ns/1ps
module rhf_fifo
#(
  parameter int W = 8,
  parameter int D = rhf_pkg::FIFO_DEPTH
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Filling side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Draining side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic          not_full;
    logic          not_empty;
  } rhf_fifo_state_t;

  rhf_fifo_state_t s;
  rhf_fifo_state_t next_s;
  logic [W-1:0]    mem [0:D-1];
  logic            push;
  logic            pull;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // Flags come from registers so the host sees a clean ready
  assign in_ready  = s.not_full;
  assign out_valid = s.not_empty;
  assign out_data  = mem[s.rp];
  assign push      = in_valid && s.not_full;
  assign pull      = out_ready && s.not_empty;

  // Pointer and level update
  always_comb
  begin
    next_s           = s;
    next_s.wp        = push ? bump(s.wp) : s.wp;
    next_s.rp        = pull ? bump(s.rp) : s.rp;
    next_s.cnt       = CW'(s.cnt + CW'(push) - CW'(pull));
    next_s.not_full  = next_s.cnt != CW'(D);
    next_s.not_empty = next_s.cnt != '0;
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s          <= '0;
      s.not_full <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem[s.wp] <= in_data;
  end
endmodule

// ---- design/rhf_framer.sv ----
// Host framed transmit framer with delivery, retry, backoff and receive filter
`timescale 1ns/1ps
module rhf_framer
#(
  parameter int GAP_CYC = rhf_pkg::RAW_GAP_CYC
)
(
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                SYS_RST,
  // Host byte stream
  input  wire logic [7:0]          HOST_DATA,
  input  wire logic                HOST_VALID,
  output logic                     HOST_READY,
  // Configuration
  input  wire logic                CFG_TX_FRAMED,
  input  wire rhf_pkg::rhf_dlv_t   CFG_DELIVERY,
  input  wire logic                CFG_IGNORE_BCAST,
  input  wire logic [7:0]          CFG_CHANNEL,
  input  wire logic [8:0]          CFG_NETWORK_PASSWORD_ID,
  input  wire logic [7:0]          CFG_MAX_RETRIES,
  input  wire logic [7:0]          CFG_BCAST_ATTEMPTS,
  input  wire logic [7:0]          CFG_DELAY_SPREAD,
  input  wire logic                CFG_ENCRYPT,
  input  wire logic [55:0]         CFG_KEY,
  input  wire logic                CFG_PARITY,
  input  wire logic                CFG_PARITY_ODD,
  input  wire logic                CFG_FULL_DUPLEX,
  input  wire logic                CFG_MODEM,
  input  wire logic                CFG_RS485,
  input  wire logic [47:0]         CFG_DEST_ADDR,
  input  wire logic [47:0]         OWN_ADDR,
  // Radio transmit side
  output logic                     RF_VALID,
  output logic [8:0]               RF_DATA,
  output logic                     RF_LAST,
  input  wire logic                RF_READY,
  output rhf_pkg::rhf_tx_hdr_t     RF_HDR,
  input  wire logic                RF_COLLIDE,
  input  wire logic                RF_ACK,
  input  wire logic [47:0]         RF_ACK_SRC,
  // Radio receive headers
  input  wire logic                RX_HDR_VALID,
  input  wire rhf_pkg::rhf_rx_hdr_t RX_HDR,
  output logic                     RX_DELIVER,
  // Status
  output logic                     PKT_DONE,
  output logic                     PKT_OK,
  output logic [8:0]               BUF_USED,
  output logic                     CHAN_ERR,
  output logic                     MODEM_LINES_EN,
  output logic                     MODEM_CONFLICT
);
  typedef struct packed {
    rhf_pkg::rhf_state_t  st;
    logic [7:0]           wr;
    logic [7:0]           rd;
    logic [7:0]           start;
    logic [7:0]           stop;
    logic [7:0]           tries;
    logic [7:0]           limit;
    logic                 framed;
    logic [15:0]          timer;
    logic [15:0]          lfsr;
    logic [47:0]          auto_dest;
    logic                 auto_set;
    logic [7:0]           chan;
    logic                 chan_err;
    rhf_pkg::rhf_tx_hdr_t hdr;
    logic                 rf_valid;
    logic [8:0]           rf_data;
    logic                 rf_last;
    logic                 done;
    logic                 ok;
    logic                 deliver;
    logic                 modem_en;
    logic                 modem_conflict;
    logic [8:0]           buf_used;
  } rhf_frm_state_t;

  rhf_frm_state_t s;
  rhf_frm_state_t n;
  logic [7:0]     buf_mem [0:rhf_pkg::BUF_BYTES-1];
  logic [7:0]     fifo_data;
  logic           fifo_valid;
  logic           pop;
  logic           net_match;
  logic           rx_ok;
  logic [7:0]     cur_byte;

  // Setting counts: zero means default, below the minimum is raised
  function automatic logic [7:0] clamp_count(input logic [7:0] c);
    if (c == 8'h00)
      return rhf_pkg::COUNT_DEFAULT;
    if (c < rhf_pkg::COUNT_MIN)
      return rhf_pkg::COUNT_MIN;
    return c;
  endfunction

  function automatic logic len_ok(input logic [7:0] l);
    return (l != 8'h00) && (l <= rhf_pkg::MAX_PAYLOAD);
  endfunction

  function automatic logic chan_ok(input logic [7:0] c);
    return (c >= rhf_pkg::CHAN_MIN) && (c <= rhf_pkg::CHAN_MAX);
  endfunction

  function automatic logic [15:0] backoff_cycles(input logic [7:0] rnd,
                                                 input logic [7:0] spread);
    logic [15:0] p;
    p = 16'(rnd & spread) * 16'(rhf_pkg::BACKOFF_SLOT_CYC);
    return p + 16'h0001;
  endfunction

  // Host bytes are buffered ahead of the parser
  rhf_fifo #(
    .W (8),
    .D (rhf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst       (SYS_RST),
    .in_data   (HOST_DATA),
    .in_valid  (HOST_VALID),
    .in_ready  (HOST_READY),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  // Receive qualification
  // network match
  assign net_match = RX_HDR_VALID && (RX_HDR.net.chan == s.chan)
                     && (RX_HDR.net.sysid == CFG_NETWORK_PASSWORD_ID);
  assign rx_ok = net_match
                 && (RX_HDR.bcast ? !CFG_IGNORE_BCAST : (RX_HDR.dest == OWN_ADDR))
                 && (CFG_TX_FRAMED || (CFG_DELIVERY != rhf_pkg::DLV_ADDR)
                     || (RX_HDR.src == CFG_DEST_ADDR));
  assign cur_byte = buf_mem[s.rd];

  // Next state
  always_comb
  begin
    n         = s;
    pop       = 1'b0;
    n.done    = 1'b0;
    n.deliver = rx_ok;
    n.lfsr    = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
    if (chan_ok(CFG_CHANNEL))
    begin
      n.chan     = CFG_CHANNEL;
      n.chan_err = 1'b0;
    end
    else
      n.chan_err = 1'b1;
    n.modem_en       = CFG_MODEM && !CFG_RS485;
    n.modem_conflict = CFG_MODEM && CFG_RS485;
    if (rx_ok && (CFG_DELIVERY == rhf_pkg::DLV_AUTO) && !s.auto_set)
    begin
      n.auto_set  = 1'b1;
      n.auto_dest = RX_HDR.src;
    end
    case (s.st)
      rhf_pkg::ST_IDLE:
      begin
        if (fifo_valid)
        begin
          pop          = 1'b1;
          n.wr         = 8'h01;
          n.start      = 8'h00;
          n.tries      = 8'h00;
          n.framed     = 1'b0;
          n.timer      = 16'h0000;
          n.hdr.enc      = CFG_ENCRYPT;
          n.hdr.key      = CFG_KEY;
          n.hdr.net      = '{chan: s.chan, sysid: CFG_NETWORK_PASSWORD_ID};
          n.hdr.nine_bit = CFG_PARITY;
          n.hdr.odd      = CFG_PARITY_ODD;
          if (CFG_DELIVERY == rhf_pkg::DLV_BCAST)
            n.hdr.dest = '1;
          else if (CFG_DELIVERY == rhf_pkg::DLV_AUTO)
            n.hdr.dest = s.auto_dest;
          else
            n.hdr.dest = CFG_DEST_ADDR;
          n.hdr.bcast = (CFG_DELIVERY == rhf_pkg::DLV_BCAST)
                        || (CFG_DELIVERY == rhf_pkg::DLV_AUTO && !s.auto_set);
          n.limit = clamp_count(n.hdr.bcast ? CFG_BCAST_ATTEMPTS : CFG_MAX_RETRIES);
          n.st    = (CFG_TX_FRAMED && fifo_data == rhf_pkg::START_BYTE)
                    ? rhf_pkg::ST_HDR : rhf_pkg::ST_RAW;
        end
      end
      rhf_pkg::ST_HDR:
      begin
        if (fifo_valid)
        begin
          pop  = 1'b1;
          n.wr = s.wr + 8'h01;
          if (s.wr == 8'h01 && !len_ok(fifo_data))
            n.st = rhf_pkg::ST_RAW;
          else if (s.wr == 8'h01)
            n.stop = fifo_data + rhf_pkg::HDR_BYTES;
          else if (s.wr == 8'h03)
            n.limit = clamp_count(fifo_data);
          else if (s.wr == 8'h04)
            n.hdr.dest[23:16] = fifo_data;
          else if (s.wr == 8'h05)
            n.hdr.dest[15:8] = fifo_data;
          else if (s.wr == 8'h06)
          begin
            n.hdr.bcast = (s.hdr.dest[23:8] == 16'hffff)
                          && (fifo_data == rhf_pkg::ALL_ONES_BYTE);
            n.hdr.dest  = n.hdr.bcast ? '1 : {OWN_ADDR[47:24], s.hdr.dest[23:8], fifo_data};
            n.framed    = 1'b1;
            n.start     = rhf_pkg::HDR_BYTES;
            n.st        = rhf_pkg::ST_PAY;
          end
        end
      end
      rhf_pkg::ST_PAY:
      begin
        if (s.wr == s.stop)
        begin
          n.st = rhf_pkg::ST_SEND;
          n.rd = s.start;
        end
        else if (fifo_valid)
        begin
          pop  = 1'b1;
          n.wr = s.wr + 8'h01;
        end
      end
      rhf_pkg::ST_RAW:
      begin
        if (fifo_valid && s.wr != rhf_pkg::MAX_PAYLOAD)
        begin
          pop     = 1'b1;
          n.wr    = s.wr + 8'h01;
          n.timer = 16'h0000;
        end
        else if (s.wr == rhf_pkg::MAX_PAYLOAD || s.timer == 16'(GAP_CYC - 1))
        begin
          n.stop = s.wr;
          n.rd   = s.start;
          n.st   = rhf_pkg::ST_SEND;
        end
        else
          n.timer = s.timer + 16'h0001;
      end
      rhf_pkg::ST_SEND:
      begin
        if (RF_COLLIDE)
        begin
          n.rf_valid = 1'b0;
          n.rf_last  = 1'b0;
          n.timer    = backoff_cycles(s.lfsr[7:0], CFG_DELAY_SPREAD);
          n.st       = rhf_pkg::ST_BACKOFF;
        end
        else if (!s.rf_valid || RF_READY)
        begin
          if (s.rd != s.stop)
          begin
            n.rf_valid = 1'b1;
            n.rf_data  = {s.hdr.nine_bit & (^cur_byte ^ s.hdr.odd), cur_byte};
            n.rf_last  = (s.rd + 8'h01) == s.stop;
            n.rd       = s.rd + 8'h01;
          end
          else
          begin
            n.rf_valid = 1'b0;
            n.rf_last  = 1'b0;
            n.tries    = s.tries + 8'h01;
            n.rd       = s.start;
            if (s.hdr.bcast && !CFG_FULL_DUPLEX)
            begin
              if (n.tries >= s.limit)
              begin
                n.st   = rhf_pkg::ST_IDLE;
                n.done = 1'b1;
                n.ok   = 1'b1;
                n.wr   = 8'h00;
              end
            end
            else
            begin
              n.timer = 16'(rhf_pkg::ACK_WAIT_CYC);
              n.st    = rhf_pkg::ST_WAIT;
            end
          end
        end
      end
      rhf_pkg::ST_WAIT:
      begin
        if (RF_COLLIDE)
        begin
          n.timer = backoff_cycles(s.lfsr[7:0], CFG_DELAY_SPREAD);
          n.st    = rhf_pkg::ST_BACKOFF;
        end
        else if (!s.hdr.bcast && RF_ACK && RF_ACK_SRC == s.hdr.dest)
        begin
          n.st   = rhf_pkg::ST_IDLE;
          n.done = 1'b1;
          n.ok   = 1'b1;
          n.wr   = 8'h00;
        end
        else if (s.timer == 16'h0000)
        begin
          if (s.tries >= s.limit)
          begin
            n.st   = rhf_pkg::ST_IDLE;
            n.done = 1'b1;
            n.ok   = s.hdr.bcast;
            n.wr   = 8'h00;
          end
          else
            n.st = rhf_pkg::ST_SEND;
        end
        else
          n.timer = s.timer - 16'h0001;
      end
      rhf_pkg::ST_BACKOFF:
      begin
        if (s.timer == 16'h0000)
        begin
          n.rd = s.start;
          n.st = rhf_pkg::ST_SEND;
        end
        else
          n.timer = s.timer - 16'h0001;
      end
      default:
        n.st = rhf_pkg::ST_IDLE;
    endcase
    n.buf_used = (n.st == rhf_pkg::ST_IDLE) ? 9'h000 : {1'b0, n.wr};
  end

  // State register
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      s           <= '0;
      s.st        <= rhf_pkg::ST_IDLE;
      s.lfsr      <= rhf_pkg::LFSR_SEED;
      s.chan      <= rhf_pkg::CHAN_MIN;
      s.limit     <= rhf_pkg::COUNT_DEFAULT;
      s.auto_dest <= '1;
    end
    else
      s <= n;
  end

  // Packet store, header included
  always_ff @(posedge CLK)
  begin
    if (pop)
      buf_mem[s.wr] <= fifo_data;
  end

  // Outputs
  assign RF_VALID       = s.rf_valid;
  assign RF_DATA        = s.rf_data;
  assign RF_LAST        = s.rf_last;
  assign RF_HDR         = s.hdr;
  assign RX_DELIVER     = s.deliver;
  assign PKT_DONE       = s.done;
  assign PKT_OK         = s.ok;
  assign BUF_USED       = s.buf_used;
  assign CHAN_ERR       = s.chan_err;
  assign MODEM_LINES_EN = s.modem_en;
  assign MODEM_CONFLICT = s.modem_conflict;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence seq_bad_len;
    s.st == rhf_pkg::ST_HDR && pop && s.wr == 8'h01 && !len_ok(fifo_data);
  endsequence
  sequence seq_bcast_addr;
    s.st == rhf_pkg::ST_HDR && pop && s.wr == 8'h06 && fifo_data == 8'hff
      && s.hdr.dest[23:8] == 16'hffff;
  endsequence

  property p_bad_header;
    seq_bad_len |=> s.st == rhf_pkg::ST_RAW ##1 s.wr >= 8'h02;
  endproperty
  a_bad_header: assert property (p_bad_header)
    else $error("bad header length not sent raw");

  property p_raw_limit;
    s.st == rhf_pkg::ST_RAW |-> s.wr <= rhf_pkg::MAX_PAYLOAD && !s.rf_valid;
  endproperty
  a_raw_limit: assert property (p_raw_limit)
    else $error("raw string exceeds payload limit");

  property p_strip;
    s.rf_valid && s.framed |-> s.rd >= 8'h08 && BUF_USED == {1'b0, s.stop};
  endproperty
  a_strip: assert property (p_strip)
    else $error("header byte on radio or released early");

  property p_bcast;
    seq_bcast_addr |=> s.hdr.bcast && s.hdr.dest == '1 && s.st == rhf_pkg::ST_PAY;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("all ones address not broadcast");

  property p_chan;
    !chan_ok(CFG_CHANNEL) |=> CHAN_ERR && s.chan == $past(s.chan);
  endproperty
  a_chan: assert property (p_chan)
    else $error("out of range channel taken");

  property p_retry_fail;
    s.st == rhf_pkg::ST_WAIT && !s.hdr.bcast && s.timer == 16'h0000 && !RF_COLLIDE
      && !RF_ACK && s.tries >= s.limit |=> PKT_DONE && !PKT_OK ##1 !PKT_DONE;
  endproperty
  a_retry_fail: assert property (p_retry_fail)
    else $error("exhausted packet not discarded");

  property p_bcast_count;
    PKT_DONE && s.hdr.bcast |-> s.tries == s.limit && PKT_OK;
  endproperty
  a_bcast_count: assert property (p_bcast_count)
    else $error("broadcast attempt count wrong");

  property p_backoff;
    (s.st == rhf_pkg::ST_SEND || s.st == rhf_pkg::ST_WAIT) && RF_COLLIDE
      |=> s.st == rhf_pkg::ST_BACKOFF && !RF_VALID && s.timer != 16'h0000;
  endproperty
  a_backoff: assert property (p_backoff)
    else $error("collision without backoff");

  property p_net;
    RX_DELIVER |-> $past(net_match);
  endproperty
  a_net: assert property (p_net)
    else $error("delivery from foreign network");

  property p_ignore;
    RX_HDR_VALID && RX_HDR.bcast && CFG_IGNORE_BCAST |=> !RX_DELIVER;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("ignored broadcast delivered");

  property p_auto;
    rx_ok && CFG_DELIVERY == rhf_pkg::DLV_AUTO && !s.auto_set
      |=> s.auto_set && s.auto_dest == $past(RX_HDR.src);
  endproperty
  a_auto: assert property (p_auto)
    else $error("first source not latched");

  property p_ack_peer;
    s.st == rhf_pkg::ST_WAIT && !s.hdr.bcast && !RF_COLLIDE && RF_ACK
      && RF_ACK_SRC == s.hdr.dest |=> PKT_DONE && PKT_OK && s.st == rhf_pkg::ST_IDLE;
  endproperty
  a_ack_peer: assert property (p_ack_peer)
    else $error("peer acknowledge not taken");
endmodule

// ---- bench/rhf_radio_peer.sv ----
// Radio peer model: takes sent bytes, stalls, answers acknowledgements
`timescale 1ns/1ps
module rhf_radio_peer
(
  // Clock
  input  wire logic                  clk,
  // Transmit stream
  input  wire logic                  rf_valid,
  input  wire logic [8:0]            rf_data,
  input  wire logic                  rf_last,
  input  wire rhf_pkg::rhf_tx_hdr_t  rf_hdr,
  output logic                       rf_ready,
  // Acknowledge back
  output logic                       rf_ack,
  output logic [47:0]                rf_ack_src,
  // Bench control
  input  wire logic                  ack_en
);
  logic [8:0] got [8];
  int         nbytes = 0;
  int         nsend = 0;
  int         acked = 0;
  int         dly = 0;
  initial
  begin
    rf_ready = 1'b0;
    rf_ack = 1'b0;
    rf_ack_src = 48'h0;
  end
  // Capture bytes taken at the edge
  always @(posedge clk)
  begin
    if (rf_valid && rf_ready)
    begin
      got[nbytes % 8] <= rf_data;
      nbytes <= nbytes + 1;
      if (rf_last)
        nsend <= nsend + 1;
    end
  end
  // Slow ready, late acknowledge, idle source toggles
  always @(negedge clk)
  begin
    rf_ready <= ~rf_ready;
    if (dly == 4)
    begin
      acked <= nsend;
      dly <= 0;
      rf_ack <= ack_en;
      rf_ack_src <= rf_hdr.dest;
    end
    else
    begin
      dly <= (acked != nsend) ? dly + 1 : 0;
      rf_ack <= 1'b0;
      rf_ack_src <= ~rf_ack_src;
    end
  end
endmodule

// ---- bench/rhf_framer_tb.sv ----
// Testbench of the framer: host stream, radio peer, receive filter
`timescale 1ns/1ps
module rhf_framer_tb;
  logic clk = 1'b0, rst = 1'b1, hv = 1'b0, fr = 1'b1, ign = 1'b0, par = 1'b1, mdm = 1'b0;
  logic r485 = 1'b0, rxv = 1'b0, ack_en = 1'b1, hr, rfv, rfl, rfr, ack, rxd, done, ok;
  logic cerr, mle, mcf, col = 1'b0, podd = 1'b0, enc = 1'b1, fdx = 1'b0;
  logic [7:0] hd = 8'h00, ch = 8'h10;
  logic [8:0] sid = 9'h005, rfd, used;
  logic [47:0] own = 48'h02a0c0112233, dst = 48'h02a0c0445566, asrc;
  rhf_pkg::rhf_tx_hdr_t hdr, hcap;
  rhf_pkg::rhf_rx_hdr_t rxh = '0;
  rhf_pkg::rhf_dlv_t dlv = rhf_pkg::DLV_ADDR;
  int num_errors = 0, cmp_count = 0, peak, base, s0, cyc, w;
  always #2 clk = ~clk;
  rhf_framer #(.GAP_CYC(20)) rhf_framer_i (.CLK(clk), .SYS_RST(rst), .HOST_DATA(hd),
    .HOST_VALID(hv), .HOST_READY(hr), .CFG_TX_FRAMED(fr), .CFG_DELIVERY(dlv),
    .CFG_IGNORE_BCAST(ign), .CFG_CHANNEL(ch), .CFG_NETWORK_PASSWORD_ID(sid),
    .CFG_MAX_RETRIES(8'h04), .CFG_BCAST_ATTEMPTS(8'h04), .CFG_DELAY_SPREAD(8'h03),
    .CFG_ENCRYPT(enc), .CFG_KEY(56'h0123456789abcd), .CFG_PARITY(par),
    .CFG_PARITY_ODD(podd), .CFG_FULL_DUPLEX(fdx), .CFG_MODEM(mdm), .CFG_RS485(r485),
    .CFG_DEST_ADDR(dst), .OWN_ADDR(own), .RF_VALID(rfv), .RF_DATA(rfd), .RF_LAST(rfl),
    .RF_READY(rfr), .RF_HDR(hdr), .RF_COLLIDE(col), .RF_ACK(ack), .RF_ACK_SRC(asrc),
    .RX_HDR_VALID(rxv), .RX_HDR(rxh), .RX_DELIVER(rxd), .PKT_DONE(done), .PKT_OK(ok),
    .BUF_USED(used), .CHAN_ERR(cerr), .MODEM_LINES_EN(mle), .MODEM_CONFLICT(mcf));
  rhf_radio_peer rhf_radio_peer_i (.clk(clk), .rf_valid(rfv), .rf_data(rfd), .rf_last(rfl),
    .rf_hdr(hdr), .rf_ready(rfr), .rf_ack(ack), .rf_ack_src(asrc), .ack_en(ack_en));
  // Verdict and end of run
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Compare one result
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Offer one host byte, held until taken
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk);
    hd = b;
    hv = 1'b1;
    while (hr !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (hr !== 1'b1)
    begin
      chk("host ready", 1, 0);
      complete_run();
    end
    @(posedge clk);
  endtask
  // Framed packet, payload 01 22 43 ...
  task automatic frame(input logic [7:0] cnt, input logic [23:0] a, input logic [7:0] len);
    base = rhf_radio_peer_i.nbytes;
    s0 = rhf_radio_peer_i.nsend;
    put(8'h81); put(len); put(8'h00); put(cnt); put(a[23:16]); put(a[15:8]); put(a[7:0]);
    for (int i = 0; i < len; i++)
      put(8'h01 + 8'h21 * i[7:0]);
    @(negedge clk);
    hv = 1'b0;
  endtask
  // Wait for packet end, tracking buffer use
  task automatic wait_done();
    int n;
    n = 0;
    peak = 0;
    while (done !== 1'b1 && n < 5000)
    begin
      @(negedge clk);
      if (used > peak)
        peak = used;
      n++;
    end
    cyc = n;
    hcap = hdr;
    if (done !== 1'b1)
    begin
      chk("done", 1, 0);
      complete_run();
    end
  endtask
  // Receive header, delivery seen one cycle later
  task automatic rx(input rhf_pkg::rhf_rx_hdr_t h, input logic e);
    @(negedge clk);
    rxh = h;
    rxv = 1'b1;
    @(negedge clk);
    rxv = 1'b0;
    chk("deliver", e, rxd);
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    frame(8'h02, 24'haabbcc, 8'h03);
    wait_done();
    for (int i = 0; i < 3; i++)
      chk("rf byte", {^(8'h01 + 8'h21 * i[7:0]), 8'h01 + 8'h21 * i[7:0]},
          rhf_radio_peer_i.got[(base + i) % 8]);
    chk("sends", 1, rhf_radio_peer_i.nsend - s0);
    chk("acked ok", 1, ok);
    chk("dest", {own[47:24], 24'haabbcc}, hcap.dest);
    chk("cipher", 1, hcap.enc);
    chk("buffer peak", 10, peak);
    ack_en = 1'b0;
    fdx = 1'b1;
    frame(8'h03, 24'hffffff, 8'h01);
    wait_done();
    fdx = 1'b0;
    chk("duplex window", 1, cyc > 1000);
    chk("bcast sends", 3, rhf_radio_peer_i.nsend - s0);
    chk("bcast", {1'b1, 48'hffffffffffff}, {hcap.bcast, hcap.dest});
    chk("bcast ok", 1, ok);
    frame(8'h02, 24'h445566, 8'h01);
    wait_done();
    chk("retry sends", 2, rhf_radio_peer_i.nsend - s0);
    chk("retry ok", 0, ok);
    ack_en = 1'b1;
    base = rhf_radio_peer_i.nbytes;
    put(8'h81); put(8'h00); put(8'h55);
    @(negedge clk);
    hv = 1'b0;
    wait_done();
    chk("raw count", 3, rhf_radio_peer_i.nbytes - base);
    chk("raw first", 9'h081, rhf_radio_peer_i.got[base % 8]);
    // encryption off in the header of the packets this framer sends next
    enc = 1'b0;
    podd = 1'b1;
    frame(8'h02, 24'h445566, 8'h01);
    w = 0;
    while (rhf_radio_peer_i.nsend == s0 && w < 100)
    begin
      @(negedge clk);
      w++;
    end
    if (rhf_radio_peer_i.nsend == s0)
    begin
      chk("first send", 1, 0);
      complete_run();
    end
    col = 1'b1;
    @(negedge clk);
    col = 1'b0;
    wait_done();
    chk("collide sends", 2, rhf_radio_peer_i.nsend - s0);
    chk("odd parity", 9'h001, rhf_radio_peer_i.got[(base + 1) % 8]);
    chk("plain ok", 2'b01, {hcap.enc, ok});
    fr = 1'b0;
    rx('{src: dst, dest: own, net: '{8'h10, 9'h005}, bcast: 1'b0}, 1'b1);
    rx('{src: dst, dest: own, net: '{8'h10, 9'h006}, bcast: 1'b0}, 1'b0);
    rx('{src: own, dest: own, net: '{8'h10, 9'h005}, bcast: 1'b0}, 1'b0);
    ign = 1'b1;
    rx('{src: dst, dest: '1, net: '{8'h10, 9'h005}, bcast: 1'b1}, 1'b0);
    ign = 1'b0;
    rx('{src: dst, dest: '1, net: '{8'h10, 9'h005}, bcast: 1'b1}, 1'b1);
    dlv = rhf_pkg::DLV_AUTO;
    rx('{src: 48'h02a0c0778899, dest: own, net: '{8'h10, 9'h005}, bcast: 1'b0}, 1'b1);
    put(8'h3c);
    @(negedge clk);
    hv = 1'b0;
    wait_done();
    chk("auto dest", {1'b0, 48'h02a0c0778899}, {hcap.bcast, hcap.dest});
    ch = 8'h30;
    mdm = 1'b1;
    r485 = 1'b1;
    repeat (3) @(negedge clk);
    chk("cfg flags", 3'b110, {cerr, mcf, mle});
    ch = 8'h2f;
    r485 = 1'b0;
    repeat (3) @(negedge clk);
    chk("cfg flags", 3'b001, {cerr, mcf, mle});
    complete_run();
  end
endmodule
